/* File: shared/cpt_pkg.sv */
// constants shared by the capture timer channel and its helpers
// assumes a single 100 MHz clock domain and plain control ports
// Functional notes
// - a 16-bit up-counter, interval timer on prescaler or event counter on pin
// - clock select 000 counts rising edges of the external input pin
// - clock select 001 counts on the first prescaler tap
// - both match-invert enables set toggle the flip-flop on either compare match alone; both matching in one step cancel
// - capture-invert enables at 0 leave the flip-flop alone on captures
// - flip-flop control write of 10 clears the flip-flop to 0
// - capture mode 011 latches into capture 0 on paired flip-flop rising
// - paired setup, rise captures into capture 0, fall into capture 1
// - capture mode 010 latches on pin rising into 0, falling into 1
// - every latch into capture 1 raises the capture-1 interrupt
// - every latch into capture 0 raises the capture-0 interrupt
// - mask pattern 101 passes only the compare-1 match interrupt
// - clear-on-match 0 lets the counter run free and wrap
// - counting and captures work only when enabled, flip-flop writes work regardless; run bits 11 start, 00 stop
// - flip-flop control 00 toggles, 01 sets, 10 clears
// - software capture bit written 0 latches the counter into capture 0
// - dma request on enabled match or capture events, blocked when masked
package cpt_pkg;
  localparam int unsigned CPT_W = 16;
  localparam logic [CPT_W-1:0] CPT_CNT_RST = 16'h0000;
  localparam logic [CPT_W-1:0] CPT_CNT_MAX = 16'hffff;
  // count clock selections
  localparam logic [2:0] CPT_CLK_PIN = 3'h0;
  localparam logic [2:0] CPT_CLK_T1 = 3'h1;
  // capture modes
  localparam logic [2:0] CPT_CPM_OFF = 3'h0;
  localparam logic [2:0] CPT_CPM_PIN = 3'h2;
  localparam logic [2:0] CPT_CPM_PAIR = 3'h3;
  // flip-flop control codes
  localparam logic [1:0] CPT_FFC_TOG = 2'h0;
  localparam logic [1:0] CPT_FFC_SET = 2'h1;
  localparam logic [1:0] CPT_FFC_CLR = 2'h2;
  // prescaler: tap n divides the clock by 2**(2n-1), tap one by 2
  // tap seven needs thirteen divider bits to reach its rollover
  localparam int unsigned CPT_PRE_W = 13;
  localparam logic [CPT_PRE_W-1:0] CPT_PRE_RST = 13'h0000;
  localparam logic [CPT_PRE_W-1:0] CPT_PRE_ONE = 13'h0001;
  localparam int unsigned CPT_TAPS = 7;
endpackage : cpt_pkg

/* File: core/cpt_sync.sv */
// two-stage synchroniser with edge detection on the settled level
// assumes the input is asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module cpt_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // the first stage feeds the second only, edges come from later stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule : cpt_sync
`default_nettype wire

/* File: core/cpt_prescaler.sv */
// run-gated prescaler, cleared while stopped, giving one-cycle tick pulses per tap
// assumes run is a level from the same clock domain
`timescale 1ns/100ps
`default_nettype none
module cpt_prescaler (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  output logic [cpt_pkg::CPT_TAPS-1:0] tick
);
  logic [cpt_pkg::CPT_PRE_W-1:0] div_r;
  logic [cpt_pkg::CPT_PRE_W-1:0] div_nxt;

  // stopping the prescaler also clears it so a restart has fixed phase
  assign div_nxt = run ? div_r + cpt_pkg::CPT_PRE_ONE : cpt_pkg::CPT_PRE_RST;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= cpt_pkg::CPT_PRE_RST;
    end else begin
      div_r <= div_nxt;
    end
  end

  // tap k ticks when the low 2k+1 bits roll over to zero
  genvar k;
  generate
    for (k = 0; k < cpt_pkg::CPT_TAPS; k++) begin : g_tap
      localparam int unsigned TB = 2 * k + 1;
      assign tick[k] = run & (div_nxt[TB-1:0] == '0);
    end
  endgenerate
endmodule : cpt_prescaler
`default_nettype wire

/* File: core/cpt_channel.sv */
// capture timer channel: counter, two compares, two captures, flip-flop
// assumes control fields are quasi-static levels on clk; pins are async
`timescale 1ns/100ps
`default_nettype none
module cpt_channel (
  input wire logic clk,
  input wire logic resetn,
  input wire logic channel_enable_bit,
  input wire logic prescaler_run_bit,
  input wire logic counter_run_bit,
  input wire logic [2:0] count_clock_select,
  input wire logic [2:0] capture_mode_field,
  input wire logic clear_on_match_bit,
  input wire logic software_capture_bit,
  input wire logic invert_on_capture1_enable,
  input wire logic invert_on_capture0_enable,
  input wire logic invert_on_match1_enable,
  input wire logic invert_on_match0_enable,
  input wire logic [1:0] flip_flop_control_field,
  input wire logic flip_flop_control_wr,
  input wire logic overflow_irq_mask,
  input wire logic match1_irq_mask,
  input wire logic match0_irq_mask,
  input wire logic [15:0] compare_reg_0,
  input wire logic [15:0] compare_reg_1,
  input wire logic [2:0] dma_enable,
  input wire logic external_input_pin,
  input wire logic paired_flip_flop,
  output logic [15:0] counter_value,
  output logic [15:0] capture_reg_0,
  output logic [15:0] capture_reg_1,
  output logic timer_output_pin,
  output logic match_interrupt,
  output logic capture0_interrupt,
  output logic capture1_interrupt,
  output logic dma_request
);
  // -------------------------------------------------------------------
  // input synchronisation
  // -------------------------------------------------------------------
  logic pin_rise;
  logic pin_fall;
  logic pair_rise;
  logic pair_fall;
  logic [cpt_pkg::CPT_TAPS-1:0] tick;

  cpt_sync u_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(external_input_pin),
    .level(),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // the paired flip-flop may sit in another block, so it is synchronised
  cpt_sync u_pair_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(paired_flip_flop),
    .level(),
    .rise(pair_rise),
    .fall(pair_fall)
  );

  // -------------------------------------------------------------------
  // prescaler and count clock
  // -------------------------------------------------------------------
  logic pre_run;
  logic cnt_run;
  assign pre_run = channel_enable_bit & prescaler_run_bit;
  assign cnt_run = channel_enable_bit & counter_run_bit;

  cpt_prescaler u_pre (
    .clk(clk),
    .resetn(resetn),
    .run(pre_run),
    .tick(tick)
  );

  logic [2:0] tap_idx;
  logic [cpt_pkg::CPT_TAPS:0] tick_ext;
  logic tap_tick;
  logic count_step;
  assign tap_idx = count_clock_select - cpt_pkg::CPT_CLK_T1;
  // selects 001..111 map onto taps one to seven; the pin code wraps to
  // the spare top bit, held low so the index never runs off the end
  assign tick_ext = {1'b0, tick};
  assign tap_tick = tick_ext[tap_idx];
  assign count_step = cnt_run & ((count_clock_select ==
    cpt_pkg::CPT_CLK_PIN) ? pin_rise : tap_tick);

  // -------------------------------------------------------------------
  // up-counter
  // -------------------------------------------------------------------
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic match0;
  logic match1;
  logic overflow;

  // compares fire on the step that lands on the value, once per hit
  assign match0 = count_step & (cnt_nxt == compare_reg_0);
  assign match1 = count_step & (cnt_nxt == compare_reg_1);
  assign overflow = count_step & (cnt_r == cpt_pkg::CPT_CNT_MAX);

  logic [15:0] cnt_inc;
  assign cnt_inc = cnt_r + 16'h0001; // wraps when left free
  assign cnt_nxt = !count_step ? cnt_r :
    (clear_on_match_bit && cnt_r == compare_reg_1) ?
    cpt_pkg::CPT_CNT_RST : cnt_inc;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= cpt_pkg::CPT_CNT_RST;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // -------------------------------------------------------------------
  // capture events
  // -------------------------------------------------------------------
  logic sw_cap_last_r;
  logic sw_cap;
  logic cap0_ev;
  logic cap1_ev;
  logic mode_pin;
  logic mode_pair;

  // only the falling write of the software bit captures, a held 0 does not
  assign sw_cap = sw_cap_last_r & ~software_capture_bit;
  assign mode_pin = capture_mode_field == cpt_pkg::CPT_CPM_PIN;
  assign mode_pair = capture_mode_field == cpt_pkg::CPT_CPM_PAIR;
  assign cap0_ev = channel_enable_bit & (sw_cap | (mode_pin & pin_rise)
    | (mode_pair & pair_rise));
  assign cap1_ev = channel_enable_bit & ((mode_pin & pin_fall)
    | (mode_pair & pair_fall));

  logic [15:0] cap0_r;
  logic [15:0] cap1_r;

  // captures hold until their own next event
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sw_cap_last_r <= 1'b1;
      cap0_r <= cpt_pkg::CPT_CNT_RST;
      cap1_r <= cpt_pkg::CPT_CNT_RST;
    end else begin
      sw_cap_last_r <= software_capture_bit;
      if (cap0_ev) begin
        cap0_r <= cnt_r;
      end
      if (cap1_ev) begin
        cap1_r <= cnt_r;
      end
    end
  end

  // -------------------------------------------------------------------
  // output flip-flop
  // -------------------------------------------------------------------
  logic ff_r;
  logic ff_nxt;
  logic ff_toggle;

  // trigger inversion only on enabled sources
  assign ff_toggle = (invert_on_match0_enable & match0)
    ^ (invert_on_match1_enable & match1)
    ^ (invert_on_capture0_enable & cap0_ev)
    ^ (invert_on_capture1_enable & cap1_ev);

  // a software write of 00, 01 or 10 outranks hardware triggers in the same cycle
  assign ff_nxt = !flip_flop_control_wr ? ff_r ^ ff_toggle :
    (flip_flop_control_field == cpt_pkg::CPT_FFC_TOG) ? ~ff_r :
    (flip_flop_control_field == cpt_pkg::CPT_FFC_SET) ? 1'b1 :
    (flip_flop_control_field == cpt_pkg::CPT_FFC_CLR) ? 1'b0 :
    ff_r ^ ff_toggle;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ff_r <= 1'b0; // undefined on paper, pinned low here
    end else begin
      ff_r <= ff_nxt;
    end
  end

  // -------------------------------------------------------------------
  // interrupts and dma request, all one-cycle pulses from flops
  // -------------------------------------------------------------------
  logic match_irq;
  logic [2:0] dma_src;
  assign match_irq = (match0 & ~match0_irq_mask) | (match1 & ~match1_irq_mask)
    | (overflow & ~overflow_irq_mask);
  // dma bit 0 match, bit 1 capture 0, bit 2 capture 1
  assign dma_src = {cap1_ev, cap0_ev, match_irq} & dma_enable;

  logic match_irq_r;
  logic cap0_irq_r;
  logic cap1_irq_r;
  logic dma_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      match_irq_r <= 1'b0;
      cap0_irq_r <= 1'b0;
      cap1_irq_r <= 1'b0;
      dma_r <= 1'b0;
    end else begin
      match_irq_r <= match_irq;
      cap0_irq_r <= cap0_ev;
      cap1_irq_r <= cap1_ev;
      dma_r <= |dma_src;
    end
  end

  assign counter_value = cnt_r;
  assign capture_reg_0 = cap0_r;
  assign capture_reg_1 = cap1_r;
  assign timer_output_pin = ff_r;
  assign match_interrupt = match_irq_r;
  assign capture0_interrupt = cap0_irq_r;
  assign capture1_interrupt = cap1_irq_r;
  assign dma_request = dma_r;
endmodule : cpt_channel
`default_nettype wire

/* File: dv/cpt_src.sv */
// pulse source standing in for the signal on the external pins
// assumes the bench sets high and low lengths in clk cycles
`timescale 1ns/100ps
`default_nettype none
module cpt_src (
  input wire logic clk,
  input wire logic [7:0] hi,
  input wire logic [7:0] lo,
  output logic pin
);
  logic [7:0] n = 8'h0;
  initial pin = 1'b0;
  // ----
  // waveform
  // ----
  // hi of zero parks the line low so no stray edge is captured
  // non-blocking on the edge, so lengths set by the bench never race
  always @(posedge clk) begin
    if (hi == 8'h0) begin
      pin <= 1'b0;
      n <= 8'h0;
    end else if (n <= 8'h1) begin
      pin <= ~pin;
      n <= pin ? lo : hi;
    end else begin
      n <= n - 8'h1;
    end
  end
endmodule : cpt_src
`default_nettype wire

/* File: dv/cpt_props.sv */
// port assertions for the capture timer channel
// assumes it is bound into cpt_channel, one clock domain
`timescale 1ns/100ps
`default_nettype none
module cpt_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic channel_enable_bit,
  input wire logic counter_run_bit,
  input wire logic invert_on_capture1_enable,
  input wire logic invert_on_capture0_enable,
  input wire logic invert_on_match0_enable,
  input wire logic [1:0] flip_flop_control_field,
  input wire logic flip_flop_control_wr,
  input wire logic overflow_irq_mask,
  input wire logic match1_irq_mask,
  input wire logic match0_irq_mask,
  input wire logic [15:0] compare_reg_0,
  input wire logic [15:0] compare_reg_1,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] capture_reg_0,
  input wire logic [15:0] capture_reg_1,
  input wire logic timer_output_pin,
  input wire logic match_interrupt,
  input wire logic capture0_interrupt,
  input wire logic capture1_interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // relations
  // ----
  // a step means the counter moved, so compares act on the new value
  a_hold_off:
    assert property (!(channel_enable_bit && counter_run_bit) |=>
      $stable(counter_value)) else $error("counter moved while off");
  a_match1_irq:
    assert property ($changed(counter_value) && !match1_irq_mask &&
      counter_value == compare_reg_1 |-> match_interrupt)
    else $error("compare 1 match gave no interrupt");
  a_masked_src:
    assert property (match_interrupt |->
      (!$past(overflow_irq_mask) && counter_value == cpt_pkg::CPT_CNT_RST) ||
      (!$past(match1_irq_mask) && counter_value == $past(compare_reg_1)) ||
      (!$past(match0_irq_mask) && counter_value == $past(compare_reg_0)))
    else $error("interrupt from a masked source");
  a_ff_match0:
    assert property ($changed(counter_value) && counter_value ==
      compare_reg_0 && compare_reg_0 != compare_reg_1 &&
      $past(invert_on_match0_enable && !flip_flop_control_wr &&
      !invert_on_capture0_enable && !invert_on_capture1_enable) |->
      $changed(timer_output_pin)) else $error("no toggle on match 0");
  a_ff_clear:
    assert property (flip_flop_control_wr && flip_flop_control_field ==
      cpt_pkg::CPT_FFC_CLR |=> !timer_output_pin)
    else $error("flip-flop not cleared");
  a_cap0_irq:
    assert property ($changed(capture_reg_0) |-> capture0_interrupt)
    else $error("capture 0 gave no interrupt");
  a_cap1_irq:
    assert property ($changed(capture_reg_1) |-> capture1_interrupt)
    else $error("capture 1 gave no interrupt");
  a_cap0_value:
    assert property ($changed(capture_reg_0) |->
      capture_reg_0 == $past(counter_value))
    else $error("capture 0 holds a wrong count");
  c_match: cover property (match_interrupt);
  c_cap0: cover property (capture0_interrupt);
  c_cap1: cover property (capture1_interrupt);
endmodule : cpt_props
bind cpt_channel cpt_props cpt_props_i (.clk, .resetn, .channel_enable_bit,
  .counter_run_bit, .invert_on_capture1_enable, .invert_on_capture0_enable,
  .invert_on_match0_enable, .flip_flop_control_field, .flip_flop_control_wr,
  .overflow_irq_mask, .match1_irq_mask, .match0_irq_mask, .compare_reg_0,
  .compare_reg_1, .counter_value, .capture_reg_0, .capture_reg_1,
  .timer_output_pin,
  .match_interrupt, .capture0_interrupt, .capture1_interrupt);
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the capture timer channel
// assumes cpt_props is bound in and cpt_src drives both pins
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [1:0] code; logic ff;} cpt_row_s;
  // write codes from a cleared start; 11 must leave the level alone
  cpt_row_s rows [7] = '{'{2'h0, 1'b1}, '{2'h3, 1'b1}, '{2'h2, 1'b0},
    '{2'h1, 1'b1}, '{2'h0, 1'b0}, '{2'h1, 1'b1}, '{2'h2, 1'b0}};
  logic clk = 1'b0, resetn = 1'b0, channel_enable_bit = 1'b0;
  logic prescaler_run_bit = 1'b0, counter_run_bit = 1'b0;
  logic clear_on_match_bit = 1'b0, software_capture_bit = 1'b1;
  logic invert_on_capture1_enable = 1'b0, invert_on_capture0_enable = 1'b0;
  logic invert_on_match1_enable = 1'b0, invert_on_match0_enable = 1'b0;
  logic flip_flop_control_wr = 1'b0, overflow_irq_mask = 1'b1;
  logic match1_irq_mask = 1'b0, match0_irq_mask = 1'b1;
  logic [1:0] flip_flop_control_field = 2'h3;
  logic [2:0] count_clock_select = 3'h1, capture_mode_field = 3'h0;
  logic [2:0] dma_enable = 3'h7;
  logic [7:0] hi = 8'h0, lo = 8'ha;
  logic [15:0] compare_reg_0 = 16'h3, compare_reg_1 = 16'h6;
  logic [15:0] counter_value, capture_reg_0, capture_reg_1;
  logic timer_output_pin, match_interrupt, capture0_interrupt;
  logic capture1_interrupt, dma_request, pin, pin_q;
  int failures = 0, checks = 0, n_m = 0, n_d = 0, n_c0 = 0, n_c1 = 0;
  int n_r = 0;
  cpt_channel cpt_channel_i (.clk, .resetn, .channel_enable_bit,
    .prescaler_run_bit, .counter_run_bit, .count_clock_select,
    .capture_mode_field, .clear_on_match_bit, .software_capture_bit,
    .invert_on_capture1_enable, .invert_on_capture0_enable,
    .invert_on_match1_enable, .invert_on_match0_enable,
    .flip_flop_control_field, .flip_flop_control_wr, .overflow_irq_mask,
    .match1_irq_mask, .match0_irq_mask, .compare_reg_0, .compare_reg_1,
    .dma_enable, .external_input_pin(pin), .paired_flip_flop(pin),
    .counter_value, .capture_reg_0, .capture_reg_1, .timer_output_pin,
    .match_interrupt, .capture0_interrupt, .capture1_interrupt,
    .dma_request);
  cpt_src cpt_src_i (.clk, .hi, .lo, .pin);
  always #5 clk = ~clk;
  // pulse tallies; counting beats sampling since pulses stand one cycle
  always @(posedge clk) begin
    pin_q <= pin;
    n_m <= n_m + (match_interrupt === 1'b1);
    n_d <= n_d + (dma_request === 1'b1);
    n_c0 <= n_c0 + (capture0_interrupt === 1'b1);
    n_c1 <= n_c1 + (capture1_interrupt === 1'b1);
    n_r <= n_r + (pin === 1'b1 && pin_q === 1'b0);
  end
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic chk16(string s, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk16
  task automatic chkn(string s, int e, int g);
    checks++;
    if (g != e) begin
      failures++;
      $display("Error %s expected %0d seen %0d", s, e, g);
    end
  endtask : chkn
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // a wait that ran out ends the run at once
  task automatic bound(logic ok);
    if (!ok) begin
      failures++;
      test_done();
    end
  endtask : bound
  // one high pulse; both captures share the sync path, so width is exact
  task automatic pw(logic [2:0] m, logic [7:0] h, logic [15:0] e);
    capture_mode_field = m;
    hi = h;
    n_c1 = 0;
    for (int i = 0; i < 500 && n_c1 == 0; i++) cyc(1);
    hi = 8'h0;
    bound(n_c1 == 1);
    chk16("width", e, capture_reg_1 - capture_reg_0);
    cyc(20);
  endtask : pw
  initial begin
    cyc(5);
    resetn = 1'b1;
    chk16("counter", 16'h0, counter_value);
    chk16("ff", 16'h0, {15'h0, timer_output_pin});
    flip_flop_control_wr = 1'b1;
    foreach (rows[i]) begin
      flip_flop_control_field = rows[i].code;
      cyc(1);
      chk16("ff", {15'h0, rows[i].ff}, {15'h0, timer_output_pin});
    end
    flip_flop_control_wr = 1'b0;
    invert_on_match1_enable = 1'b1;
    invert_on_match0_enable = 1'b1;
    {channel_enable_bit, prescaler_run_bit, counter_run_bit} = 3'h7;
    for (int i = 0; i < 100 && counter_value !== 16'h4; i++) cyc(1);
    bound(counter_value === 16'h4);
    chk16("ff", 16'h1, {15'h0, timer_output_pin});
    cyc(10);
    chk16("counter", 16'h9, counter_value);
    {prescaler_run_bit, counter_run_bit} = 2'h0;
    chk16("ff", 16'h0, {15'h0, timer_output_pin});
    chkn("match irqs", 1, n_m);
    chkn("dma", 1, n_d);
    software_capture_bit = 1'b0;
    cyc(6);
    chk16("counter", 16'h9, counter_value);
    chk16("soft cap", 16'h9, capture_reg_0);
    chkn("cap0 irqs", 1, n_c0);
    {channel_enable_bit, prescaler_run_bit, counter_run_bit} = 3'h3;
    software_capture_bit = 1'b1;
    cyc(6);
    chk16("counter", 16'h9, counter_value);
    channel_enable_bit = 1'b1;
    pw(3'h2, 8'h14, 16'ha);
    pw(3'h3, 8'h1e, 16'hf);
    // event count after a mid-run reset, compare 0 now unmasked
    {count_clock_select, capture_mode_field, dma_enable} = 9'h001;
    compare_reg_0 = 16'h4;
    match0_irq_mask = 1'b0;
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    {n_m, n_d, n_r} = 96'h0;
    {hi, lo} = 16'h0303;
    cyc(60);
    hi = 8'h0;
    cyc(8);
    chk16("events", n_r[15:0], counter_value);
    chkn("match irqs", 2, n_m);
    chkn("dma", 2, n_d);
    // clear on match: the count runs through compare 1 back to zero
    clear_on_match_bit = 1'b1;
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    n_r = 0;
    hi = 8'h3;
    cyc(80);
    hi = 8'h0;
    cyc(8);
    chk16("clear", 16'(n_r % (compare_reg_1 + 16'h1)), counter_value);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
